// File: design/lin_ctrl_params.svh
// Register offsets, field positions, reset values and timing counts for the line control block
`ifndef LIN_CTRL_PARAMS_SVH
`define LIN_CTRL_PARAMS_SVH

`define LINE_CONTROL_ADDR      8'h00
`define LINE_STATUS_ADDR       8'h04
`define LINE_CONTROL_RESET     8'h03
`define LINE_STATUS_RESET      8'h00
`define TX_BIT                 0
`define RX_BIT                 1
`define TIMEOUT_BIT            2
`define SLEW_LSB               3
`define UNLIMITED_BIT          5
`define PIN_CHECK_BIT          6
`define OVERTEMP_BIT           7
`define SHORT_ERR_BIT          0
`define DOMINANT_MAX_US        6000
`define CLOCK_MHZ              100
`define DOMINANT_MAX_CYCLES    (`DOMINANT_MAX_US * `CLOCK_MHZ)

`endif

// File: design/lin_ctrl_pkg.sv
// Types for the line control block
package lin_ctrl_pkg;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_t;
endpackage

// File: design/lin_driver_fault_control.sv
// Transmitter control, dominant timeout and fault protection for a single-wire bus
//
// How it works
// - Overtemp keeps transmitter off until temperature clears
// - Pin check enable adds input pin to short check
// - Otherwise only software transmit bit is checked
// - Unlimited bit disables the dominant timeout
// - Timeout disables transmitter, sets error bit two
// - Both levels high re-enables transmitter, clears error
// - Either source dominant counts toward the timeout
// - Receive bit one mirrors line, resets high
// - Line level is pin AND software bit
// - Short error forces transmit bit, blocks clearing
// - Timeout error stops software bit pulling low
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "lin_ctrl_params.svh"

module lin_driver_fault_control
   import lin_ctrl_pkg::*;
#(
   parameter int unsigned DOMINANT_MAX = `DOMINANT_MAX_CYCLES,
   parameter int unsigned CNT_W        = 24
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Pins and fault detectors
   input  wire logic        txd_pin,
   input  wire logic        line_rx,
   input  wire logic        overtemp_in,
   input  wire logic        short_detect_in,
   // Transmitter
   output logic             line_drive_low,
   output logic             tx_enable,
   output logic [1:0]       slew_select
);

   // Refuse a counter that cannot hold the programmed maximum dominant time
   if (CNT_W < 2 || CNT_W > 32 || DOMINANT_MAX < 1 ||
       (CNT_W < 32 && DOMINANT_MAX >= (64'd1 << CNT_W))) begin : g_bad_width
      $error("lin_driver_fault_control: counter too narrow for DOMINANT_MAX");
   end

   localparam logic [CNT_W-1:0] MAX_CNT = CNT_W'(DOMINANT_MAX);

   typedef struct packed {
      bus_state_t       bus;
      logic [31:0]      rdata;
      logic [1:0]       txd_sync;
      logic [1:0]       rx_sync;
      logic [1:0]       temp_sync;
      logic [1:0]       short_sync;
      logic             tx_bit;
      logic [1:0]       slew;
      logic             unlimited;
      logic             pin_check;
      logic             timeout_err;
      logic             overtemp_err;
      logic             short_err;
      logic             rx_level;
      logic [CNT_W-1:0] dom_cnt;
      logic             drive_low;
      logic             tx_en;
   } state_t;

   state_t s_reg;
   state_t s_next;

   logic       req;
   logic       wr_ctrl;
   logic       wr_stat;
   logic       dominant;
   logic       short_seen;
   logic [7:0] ctrl_view;

   always_comb begin
      req       = wb_cyc_i && wb_stb_i && (s_reg.bus == BUS_IDLE);
      wr_ctrl   = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `LINE_CONTROL_ADDR);
      wr_stat   = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `LINE_STATUS_ADDR);
      ctrl_view = {s_reg.overtemp_err, s_reg.pin_check, s_reg.unlimited, s_reg.slew,
                   s_reg.timeout_err, s_reg.rx_level, s_reg.tx_bit};
      // Dominant request from either source
      dominant  = !(s_reg.txd_sync[1] && s_reg.tx_bit);
      // Detector only meaningful while one of the checked sources asks for dominant
      short_seen = s_reg.short_sync[1] &&
                   (s_reg.pin_check ? dominant
                                    : !s_reg.tx_bit);

      s_next = s_reg;
      s_next.txd_sync   = {s_reg.txd_sync[0], txd_pin};
      s_next.rx_sync    = {s_reg.rx_sync[0], line_rx};
      s_next.temp_sync  = {s_reg.temp_sync[0], overtemp_in};
      s_next.short_sync = {s_reg.short_sync[0], short_detect_in};

      s_next.rx_level     = s_reg.rx_sync[1];
      s_next.overtemp_err = s_reg.temp_sync[1];

      // Set wins over a software clear in the same cycle
      if (wr_stat && wb_dat_i[`SHORT_ERR_BIT])
         s_next.short_err = 1'b0;
      if (short_seen)
         s_next.short_err = 1'b1;

      if (wr_ctrl) begin
         s_next.tx_bit    = wb_dat_i[`TX_BIT];
         s_next.slew      = wb_dat_i[`SLEW_LSB +: 2];
         s_next.unlimited = wb_dat_i[`UNLIMITED_BIT];
         s_next.pin_check = wb_dat_i[`PIN_CHECK_BIT];
      end
      if (s_reg.short_err || short_seen)
         s_next.tx_bit = 1'b1;

      // Dominant duration counter
      if (!dominant || s_reg.unlimited)
         s_next.dom_cnt = '0;
      else if (s_reg.dom_cnt != MAX_CNT)
         s_next.dom_cnt = s_reg.dom_cnt + CNT_W'(1);

      if (!s_reg.unlimited && dominant && s_reg.dom_cnt == MAX_CNT)
         s_next.timeout_err = 1'b1;
      else if (s_reg.timeout_err && !dominant)
         s_next.timeout_err = 1'b0;

      // Transmitter off while the timeout or overtemp error holds
      s_next.tx_en     = !s_next.timeout_err && !s_next.overtemp_err;
      s_next.drive_low = dominant && s_next.tx_en;

      unique case (s_reg.bus)
         BUS_IDLE: begin
            if (req) begin
               s_next.bus = BUS_ACK;
               if (wb_we_i)
                  s_next.rdata = '0;
               else if (wb_adr_i == `LINE_CONTROL_ADDR)
                  s_next.rdata = {24'h000000, ctrl_view};
               else if (wb_adr_i == `LINE_STATUS_ADDR)
                  s_next.rdata = {31'h00000000, s_reg.short_err};
               else
                  s_next.rdata = '0;
            end
         end
         BUS_ACK: begin
            s_next.bus   = BUS_IDLE;
            s_next.rdata = '0;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s_reg              <= '0;
         s_reg.bus          <= BUS_IDLE;
         s_reg.txd_sync     <= 2'h3;
         s_reg.rx_sync      <= 2'h3;
         s_reg.tx_bit       <= 1'b1;
         s_reg.rx_level     <= 1'b1;
         s_reg.tx_en        <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   always_comb begin
      wb_dat_o       = s_reg.rdata;
      wb_ack_o       = (s_reg.bus == BUS_ACK);
      line_drive_low = s_reg.drive_low;
      tx_enable      = s_reg.tx_en;
      slew_select    = s_reg.slew;
   end

endmodule // lin_driver_fault_control

// File: verif/lin_bus_model.sv
// Bus line with pull-up, and the host's transmit pin
`timescale 1ns/1ps
module lin_bus_model (
   input wire logic line_drive_low, tx_enable, pin_req,
   output logic     txd_pin, line_rx
);
   assign txd_pin = pin_req;
   assign line_rx = !(line_drive_low && tx_enable);
endmodule // lin_bus_model

// File: verif/lin_ctrl_props.sv
// Port assertions for the line control block
`timescale 1ns/1ps
module lin_ctrl_props #(parameter int unsigned DOMINANT_MAX = 50) (
   input wire logic mclk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, txd_pin,
   input wire logic line_rx, overtemp_in, line_drive_low, tx_enable,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i, wb_dat_o
);
   logic [1:0] ctl_reg;
   int run_reg;
   wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr = tk && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0];
   // Mirror of the unlimited and transmit bits as last written
   always_ff @(posedge mclk) begin
      if (!rstn) ctl_reg <= 2'b01;
      else if (wr) ctl_reg <= {wb_dat_i[5], wb_dat_i[0]};
      run_reg <= (rstn && line_drive_low) ? run_reg + 1 : 0;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   property p_ack; tk |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_unm; tk && wb_adr_i != 8'h00 && wb_adr_i != 8'h04 |=> wb_dat_o == 32'h0; endproperty
   a_unm: assert property (p_unm) else $error("unmapped data");
   property p_hot; overtemp_in [*5] |-> !tx_enable; endproperty
   a_hot: assert property (p_hot) else $error("hot enable");
   property p_max; !ctl_reg[1] |-> run_reg <= DOMINANT_MAX + 4; endproperty
   a_max: assert property (p_max) else $error("long dominant");
   property p_pin; line_drive_low && ctl_reg[0] && $past(ctl_reg[0], 3) |-> !$past(txd_pin, 3);
   endproperty
   a_pin: assert property (p_pin) else $error("drive cause");
   property p_back; (txd_pin && ctl_reg[0] && !overtemp_in) [*6] |-> tx_enable; endproperty
   a_back: assert property (p_back) else $error("no recovery");
   property p_unl; $fell(tx_enable) |-> $past(overtemp_in, 3) || !$past(ctl_reg[1], 3); endproperty
   a_unl: assert property (p_unl) else $error("unlimited cut");
   property p_rx; $stable(line_rx) [*3] ##0 tk && !wb_we_i && wb_adr_i == 8'h00
      |=> wb_dat_o[1] == $past(line_rx); endproperty
   a_rx: assert property (p_rx) else $error("rx bit");
   c_to: cover property ($fell(tx_enable) && !overtemp_in);
   c_unl: cover property (ctl_reg[1] && run_reg > DOMINANT_MAX);
   c_hot: cover property (overtemp_in && !tx_enable);
endmodule // lin_ctrl_props
bind lin_driver_fault_control lin_ctrl_props #(.DOMINANT_MAX(DOMINANT_MAX)) i_props (.*);

// File: verif/tb_top.sv
// Self-checking bench for the line control block
`timescale 1ns/1ps
module tb_top;
   logic mclk = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, pin_req = 1;
   logic overtemp_in = 0, short_detect_in = 0, wb_ack_o, line_drive_low, tx_enable;
   logic txd_pin, line_rx;
   logic [7:0] wb_adr_i = 0;
   logic [3:0] wb_sel_i = 4'h1;
   logic [31:0] wb_dat_i = 0, wb_dat_o;
   logic [1:0] slew_select;
   int fails = 0, check_count = 0, sl;
   lin_driver_fault_control #(.DOMINANT_MAX(50)) i_lin_driver_fault_control (.*);
   lin_bus_model i_lin_bus_model (.*);
   initial forever #5 mclk = ~mclk;
   initial begin
      w(4000);
      fails++;
      stop_test();
   end
   task automatic w(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic stop_test;
      if (fails == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input int e);
      check_count++;
      if (got !== e) $display("ERROR %s expected %0h seen %0h", nm, e, got);
      if (got !== e) fails++;
   endtask
   // A read passes its expected value in d
   task automatic bus(input logic we, input logic [7:0] a, input int d, input string nm = "");
      @(posedge mclk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      if (!we) chk(nm, wb_dat_o, d);
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   initial begin
      void'($urandom(32'h609f));
      w(3);
      rstn <= 1;
      bus(0, 0, 8'h03, "reset");
      bus(0, 8'h10, 0, "unmapped");
      sl = $urandom_range(3);
      bus(1, 0, 8'h87 | sl << 3);
      bus(0, 0, 8'h03 | sl << 3, "control");
      chk("slew", slew_select, sl);
      bus(1, 0, 0);
      w(4);
      bus(0, 0, 0, "rx low");
      chk("drive low", line_drive_low, 1);
      w(70);
      bus(0, 0, 8'h06, "timeout");
      bus(1, 0, 1);
      w(5);
      bus(0, 0, 8'h03, "recover");
      for (int u = 1; u >= 0; u--) begin
         bus(1, 0, 1 | u << 5);
         pin_req <= 0;
         w(100);
         chk("pin enable", tx_enable, u);
         pin_req <= 1;
         w(6);
      end
      overtemp_in <= 1;
      w(5);
      bus(0, 0, 8'h83, "overtemp");
      overtemp_in <= 0;
      // Pin check off, pin check on, then software bit alone
      for (int p = 0; p < 3; p++) begin
         bus(1, 0, p < 2 ? 8'h21 | p << 6 : 0);
         pin_req <= p == 2;
         short_detect_in <= 1;
         w(5);
         {pin_req, short_detect_in} <= 2'b10;
         w(4);
         bus(1, 0, p == 0);
         bus(0, 0, 8'h03, "forced tx");
         bus(0, 4, p > 0, "short");
         bus(1, 4, 1);
      end
      stop_test();
   end
endmodule // tb_top
